// [common/alu_pkg.sv]
package alu_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] BREG_RST = 8'h00;
  localparam logic [15:0] DATA_POINTER_RST = 16'h0000;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam int unsigned PSW_CY = 7;
  localparam int unsigned PSW_AC = 6;
  localparam int unsigned PSW_OV = 2;
  localparam int unsigned PSW_RS1 = 4;
  localparam int unsigned PSW_RS0 = 3;
  // operand form in low bits of class opcodes
  localparam logic [3:0] FRM_IMM = 4'h4;
  localparam logic [3:0] FRM_DIR = 4'h5;
  localparam logic [3:0] FRM_IND0 = 4'h6;
  localparam logic [3:0] FRM_IND1 = 4'h7;
  localparam logic [3:0] FRM_DIR_A = 4'h2;
  localparam logic [3:0] FRM_DIR_IMM = 4'h3;
  // high nibbles of the opcode classes
  localparam logic [3:0] HI_ADD = 4'h2;
  localparam logic [3:0] HI_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] HI_LOGICAL_OR_OP = 4'h4;
  localparam logic [3:0] HI_LOGICAL_AND_OP = 4'h5;
  localparam logic [3:0] HI_LOGICAL_XOR_OP = 4'h6;
  localparam logic [3:0] HI_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] HI_INC = 4'h0;
  localparam logic [3:0] HI_DEC = 4'h1;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_ROTATE_RIGHT_VIA_CARRY = 8'h13;
  localparam logic [7:0] OP_RL = 8'h23;
  localparam logic [7:0] OP_ROTATE_LEFT_VIA_CARRY = 8'h33;
  localparam logic [7:0] OP_INC_A = 8'h04;
  localparam logic [7:0] OP_DEC_A = 8'h14;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_INC_DP = 8'hA3;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_DA = 8'hD4;
  localparam logic [7:0] OP_CLR = 8'hE4;
  localparam logic [7:0] OP_CPL = 8'hF4;

  typedef enum logic [1:0] {
    ALU_IDLE = 2'b00,
    ALU_BUSY = 2'b01,
    ALU_DONE = 2'b11
  } alu_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] operand1;
    logic [7:0] operand2;
    logic [7:0] mem_data;
  } alu_req_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } alu_mem_s;
endpackage : alu_pkg

// [hdl/alu_core.sv]
`timescale 1ns/100ps
// pure combinational evaluation of one instruction
module alu_core import alu_pkg::*; (
  input wire logic [7:0] opcode,
  input wire logic [7:0] acc,
  input wire logic [7:0] breg,
  input wire logic [7:0] src,
  input wire logic [7:0] imm,
  input wire logic [15:0] sixteen_bit_data_pointer,
  input wire logic [7:0] psw,
  output logic [7:0] res_acc,
  output logic [7:0] res_b,
  output logic [7:0] res_mem,
  output logic [15:0] res_data_pointer,
  output logic [7:0] res_psw,
  output logic wr_acc,
  output logic wr_mem,
  output logic [2:0] cycles
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic cy;
  logic [8:0] sum;
  logic [4:0] half;
  logic [15:0] prod;
  logic [8:0] da_t;
  logic opnd;
  logic cin;
  logic [7:0] with_acc;
  logic [7:0] with_imm;
  always_comb begin
    hi = opcode[7:4];
    lo = opcode[3:0];
    cy = psw[PSW_CY];
    res_acc = acc;
    res_b = breg;
    res_mem = src;
    res_data_pointer = sixteen_bit_data_pointer;
    res_psw = psw;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    cycles = CYC_ONE;
    sum = 9'h000;
    half = 5'h00;
    prod = 16'h0000;
    da_t = 9'h000;
    // immediate form is an accumulator source as well
    opnd = (lo >= FRM_IMM);
    cin = (hi == HI_ADD_WITH_CARRY) & cy;
    with_acc = acc ^ src;
    with_imm = imm ^ src;
    if (hi == HI_LOGICAL_AND_OP) begin
      with_acc = acc & src;
      with_imm = imm & src;
    end else if (hi == HI_LOGICAL_OR_OP) begin
      with_acc = acc | src;
      with_imm = imm | src;
    end
    if (opnd && (hi == HI_ADD || hi == HI_ADD_WITH_CARRY)) begin
      // carry-in only for the with-carry class
      sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
      half = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
      res_acc = sum[7:0];
      wr_acc = 1'b1;
      res_psw[PSW_CY] = sum[8];
      res_psw[PSW_AC] = half[4];
      res_psw[PSW_OV] = (acc[7] == src[7]) && (sum[7] != acc[7]);
    end else if (opnd && hi == HI_SUBTRACT_WITH_BORROW) begin
      sum = {1'b0, acc} - {1'b0, src} - {8'h00, cy};
      half = {1'b0, acc[3:0]} - {1'b0, src[3:0]} - {4'h0, cy};
      res_acc = sum[7:0];
      wr_acc = 1'b1;
      res_psw[PSW_CY] = sum[8];
      res_psw[PSW_AC] = half[4];
      res_psw[PSW_OV] = (acc[7] != src[7]) && (sum[7] != acc[7]);
    end else if (hi == HI_LOGICAL_AND_OP || hi == HI_LOGICAL_OR_OP ||
        hi == HI_LOGICAL_XOR_OP) begin
      // logic ops never touch the flags here; alu_unit still recomputes parity from the result
      if (opnd) begin
        wr_acc = 1'b1;
        res_acc = with_acc;
      end else if (lo == FRM_DIR_A) begin
        wr_mem = 1'b1;
        res_mem = with_acc;
      end else if (lo == FRM_DIR_IMM) begin
        wr_mem = 1'b1;
        cycles = CYC_TWO;
        res_mem = with_imm;
      end
    end else if ((hi == HI_INC || hi == HI_DEC) && lo >= FRM_DIR) begin
      wr_mem = 1'b1;
      res_mem = (hi == HI_INC) ? src + 8'h01 : src - 8'h01;
    end else begin
      case (opcode)
        OP_INC_A: begin wr_acc = 1'b1; res_acc = acc + 8'h01; end
        OP_DEC_A: begin wr_acc = 1'b1; res_acc = acc - 8'h01; end
        OP_INC_DP: begin
          res_data_pointer = sixteen_bit_data_pointer + 16'h0001;
          cycles = CYC_TWO;
        end
        OP_MUL: begin
          prod = acc * breg;
          res_acc = prod[7:0];
          res_b = prod[15:8];
          wr_acc = 1'b1;
          cycles = CYC_FOUR;
          res_psw[PSW_CY] = 1'b0;
          res_psw[PSW_OV] = (prod[15:8] != 8'h00);
        end
        OP_DIV: begin
          wr_acc = 1'b1;
          cycles = CYC_FOUR;
          res_psw[PSW_CY] = 1'b0;
          res_psw[PSW_OV] = (breg == 8'h00);
          if (breg != 8'h00) begin
            res_acc = acc / breg;
            res_b = acc % breg;
          end
        end
        OP_DA: begin
          wr_acc = 1'b1;
          da_t = {cy, acc};
          if (psw[PSW_AC] || da_t[3:0] > 4'h9) da_t = da_t + 9'h006;
          if (da_t[8] || da_t[7:4] > 4'h9) da_t = da_t + 9'h060;
          res_acc = da_t[7:0];
          res_psw[PSW_CY] = cy | da_t[8];
        end
        OP_CLR: begin wr_acc = 1'b1; res_acc = 8'h00; end
        OP_CPL: begin wr_acc = 1'b1; res_acc = ~acc; end
        OP_SWAP: begin wr_acc = 1'b1; res_acc = {acc[3:0], acc[7:4]}; end
        OP_RL: begin wr_acc = 1'b1; res_acc = {acc[6:0], acc[7]}; end
        OP_RR: begin wr_acc = 1'b1; res_acc = {acc[0], acc[7:1]}; end
        OP_ROTATE_LEFT_VIA_CARRY: begin
          wr_acc = 1'b1;
          res_acc = {acc[6:0], cy};
          res_psw[PSW_CY] = acc[7];
        end
        OP_ROTATE_RIGHT_VIA_CARRY: begin
          wr_acc = 1'b1;
          res_acc = {cy, acc[7:1]};
          res_psw[PSW_CY] = acc[0];
        end
        default: begin
          res_acc = acc;
        end
      endcase
    end
  end
endmodule : alu_core

// [hdl/alu_unit.sv]
`timescale 1ns/100ps
module alu_unit import alu_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire alu_req_s req,
  output alu_mem_s mem_wr,
  output logic [7:0] src_addr,
  output logic busy,
  output logic done,
  output logic [7:0] acc,
  output logic [7:0] breg,
  output logic [15:0] sixteen_bit_data_pointer,
  output logic [7:0] psw
);
  alu_state_e state;
  alu_state_e next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] next_acc;
  logic [7:0] next_breg;
  logic [15:0] next_sixteen_bit_data_pointer;
  logic [7:0] next_psw;
  alu_mem_s next_mem_wr;
  logic next_busy;
  logic next_done;
  logic [7:0] r_acc;
  logic [7:0] r_b;
  logic [7:0] r_mem;
  logic [15:0] r_data_pointer;
  logic [7:0] r_psw;
  logic w_acc;
  logic w_mem;
  logic [2:0] cycles;
  logic [7:0] hold_op;
  logic [7:0] next_hold_op;
  logic [7:0] hold_src;
  logic [7:0] next_hold_src;
  logic [7:0] hold_imm;
  logic [7:0] next_hold_imm;
  logic [7:0] hold_addr;
  logic [7:0] next_hold_addr;
  logic [7:0] next_src_addr;
  logic [7:0] dst_addr;
  logic [3:0] lo;
  logic [4:0] bank;

  // the request is evaluated from held copies so a multi-cycle op is stable
  alu_core u_core (
    .opcode(hold_op),
    .acc(acc),
    .breg(breg),
    .src(hold_src),
    .imm(hold_imm),
    .sixteen_bit_data_pointer(sixteen_bit_data_pointer),
    .psw(psw),
    .res_acc(r_acc),
    .res_b(r_b),
    .res_mem(r_mem),
    .res_data_pointer(r_data_pointer),
    .res_psw(r_psw),
    .wr_acc(w_acc),
    .wr_mem(w_mem),
    .cycles(cycles)
  );

  // operand address for the memory side, decoded from the request and registered each cycle
  always_comb begin
    lo = req.opcode[3:0];
    bank = {1'b0, psw[PSW_RS1], psw[PSW_RS0], 2'b00} << 1;
    if (lo >= 4'h8) begin
      next_src_addr = {3'b000, bank} + {5'h00, lo[2:0]};
    end else if (lo == FRM_IND0 || lo == FRM_IND1) begin
      // pointer register value arrives as operand1 from the sequencer
      next_src_addr = req.operand1;
    end else begin
      next_src_addr = req.operand1;
    end
  end

  always_comb begin
    dst_addr = hold_addr;
    next_state = state;
    next_cnt = cnt;
    next_acc = acc;
    next_breg = breg;
    next_sixteen_bit_data_pointer = sixteen_bit_data_pointer;
    next_psw = psw;
    next_mem_wr = '0;
    next_busy = busy;
    next_done = 1'b0;
    next_hold_op = hold_op;
    next_hold_src = hold_src;
    next_hold_imm = hold_imm;
    next_hold_addr = hold_addr;
    case (state)
      ALU_IDLE: begin
        if (req.valid) begin
          // register/indirect source data comes on mem_data; immediate is operand
          next_hold_op = req.opcode;
          next_hold_addr = next_src_addr;
          next_hold_src = (req.opcode[3:0] == FRM_IMM) ? req.operand1 : req.mem_data;
          next_hold_imm = req.operand2;
          next_state = ALU_BUSY;
          next_busy = 1'b1;
          next_cnt = 3'h1;
        end
      end
      ALU_BUSY: begin
        if (cnt >= cycles) begin
          if (w_acc) next_acc = r_acc;
          next_breg = r_b;
          next_sixteen_bit_data_pointer = r_data_pointer;
          next_psw = {r_psw[7:1], ^(w_acc ? r_acc : acc)};
          next_mem_wr = '{wr: w_mem, addr: dst_addr, data: r_mem};
          next_done = 1'b1;
          next_busy = 1'b0;
          next_state = ALU_DONE;
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end
      ALU_DONE: begin
        next_state = ALU_IDLE;
      end
      default: begin
        next_state = ALU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ALU_IDLE;
      cnt <= 3'h0;
      acc <= ACC_RST;
      breg <= BREG_RST;
      sixteen_bit_data_pointer <= DATA_POINTER_RST;
      psw <= PSW_RST;
      mem_wr <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      hold_op <= 8'h00;
      hold_src <= 8'h00;
      hold_imm <= 8'h00;
      hold_addr <= 8'h00;
      src_addr <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc <= next_acc;
      breg <= next_breg;
      sixteen_bit_data_pointer <= next_sixteen_bit_data_pointer;
      psw <= next_psw;
      mem_wr <= next_mem_wr;
      busy <= next_busy;
      done <= next_done;
      hold_op <= next_hold_op;
      hold_src <= next_hold_src;
      hold_imm <= next_hold_imm;
      hold_addr <= next_hold_addr;
      src_addr <= next_src_addr;
    end
  end

  add_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode[7:4] == HI_ADD && req.opcode[3:0] >= FRM_IMM)
    |=> ##1 done) else $error("add did not finish in one cycle");
  carry_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode[7:4] == HI_ADD_WITH_CARRY &&
      req.opcode[3:0] >= FRM_IMM) |=> !done ##1 done)
    else $error("add with carry timing wrong");
  borrow_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode[7:4] == HI_SUBTRACT_WITH_BORROW &&
      req.opcode[3:0] >= FRM_IMM) |=> ##1 done)
    else $error("subtract timing wrong");
  mul_four_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode == OP_MUL)
    |=> !done [*4] ##1 done) else $error("multiply not four cycles");
  ptr_increment_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode == OP_INC_DP)
    |=> !done [*2] ##1 (done &&
      sixteen_bit_data_pointer == $past(sixteen_bit_data_pointer, 3) + 16'h0001))
    else $error("pointer increment wrong");
  and_imm_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode == {HI_LOGICAL_AND_OP, FRM_DIR_IMM})
    |=> !done ##1 !done ##1 (mem_wr.wr && done)) else $error("and to byte wrong");
  or_imm_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode == {HI_LOGICAL_OR_OP, FRM_DIR_IMM})
    |=> ##2 (mem_wr.wr && done)) else $error("or to byte wrong");
  xor_acc_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == ALU_IDLE && req.valid && req.opcode == {HI_LOGICAL_XOR_OP, FRM_DIR_A})
    |=> ##1 (mem_wr.wr && done)) else $error("xor to byte wrong");
  logic_keeps_cy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (done && (hold_op[7:4] == HI_LOGICAL_AND_OP || hold_op[7:4] == HI_LOGICAL_OR_OP ||
      hold_op[7:4] == HI_LOGICAL_XOR_OP)) |-> psw[PSW_CY] == $past(psw[PSW_CY]))
    else $error("logic op changed carry");
endmodule : alu_unit

// [tb/alu_mem_model.sv]
`timescale 1ns/100ps
module alu_mem_model import alu_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire alu_mem_s mem_wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [7:0] wr_count
);
  logic [7:0] mem [256];
  // unwritten bytes read as their inverted address, never as a stale value
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~8'(i);
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_count <= 8'h00;
    end else if (mem_wr.wr) begin
      mem[mem_wr.addr] <= mem_wr.data;
      wr_count <= wr_count + 8'h01;
    end
  end
  assign rd_data = mem[rd_addr];
endmodule : alu_mem_model

// [tb/accumulator_arith_logic_unit_test.sv]
`timescale 1ns/100ps
module accumulator_arith_logic_unit_test import alu_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  alu_req_s req = '0;
  alu_mem_s mem_wr;
  logic [7:0] src_addr, acc, breg, psw, rd_data, wr_count;
  logic [7:0] rd_addr = 8'h00;
  logic busy, done;
  logic [15:0] sixteen_bit_data_pointer;
  int fails = 0;
  int check_count = 0;
  logic [7:0] e_acc, e_psw;
  logic [3:0] forms [4] = '{4'h4, 4'h5, 4'h7, 4'hE};
  logic [7:0] vals [4] = '{8'h7F, 8'h01, 8'h80, 8'h05};
  logic [7:0] wb_ops [4] = '{8'h53, 8'h43, 8'h63, 8'h62};
  logic [7:0] wb_exp [3] = '{8'h24, 8'hBE, 8'h9A};

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  alu_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .mem_wr(mem_wr),
    .src_addr(src_addr), .busy(busy), .done(done), .acc(acc), .breg(breg),
    .sixteen_bit_data_pointer(sixteen_bit_data_pointer), .psw(psw));
  alu_mem_model mem_u (.clk_sys(clk_sys), .rst_n(rst_n), .mem_wr(mem_wr),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_count(wr_count));

  task automatic give_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic wait_done(inout int k);
    while (k < 20 && done !== 1'b1) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 20) begin
      fails++;
      give_verdict();
    end
  endtask : wait_done

  // k counts rising edges after the one that took the request
  task automatic do_op(input logic [7:0] op, a, b, md, input logic [2:0] n);
    int k;
    k = 0;
    req <= '{1'b1, op, a, b, md};
    @(negedge clk_sys);
    req.valid <= 1'b0;
    wait_done(k);
    chk8(8'(k), 8'(n));
    @(negedge clk_sys);
    chk8({7'h00, done}, 8'h00);
  endtask : do_op

  task automatic set_acc(input logic [7:0] v);
    e_acc = v;
    e_psw[0] = ^v;
  endtask : set_acc

  task automatic chk_state();
    chk8(acc, e_acc);
    chk8(psw, e_psw);
  endtask : chk_state

  task automatic exp_arith(input logic [7:0] b, input logic ci, input logic sub);
    logic [8:0] r;
    logic ac;
    if (sub) begin
      r = {1'b0, e_acc} - {1'b0, b} - 9'(ci);
      ac = {1'b0, e_acc[3:0]} < ({1'b0, b[3:0]} + 5'(ci));
      e_psw[PSW_OV] = (e_acc[7] != b[7]) && (r[7] != e_acc[7]);
    end else begin
      r = {1'b0, e_acc} + {1'b0, b} + 9'(ci);
      ac = ({1'b0, e_acc[3:0]} + {1'b0, b[3:0]} + 5'(ci)) > 5'h0F;
      e_psw[PSW_OV] = (e_acc[7] == b[7]) && (r[7] != e_acc[7]);
    end
    e_psw[PSW_CY] = r[8];
    e_psw[PSW_AC] = ac;
    set_acc(r[7:0]);
  endtask : exp_arith

  task automatic s_reset();
    chk8(acc, ACC_RST);
    chk8(breg, BREG_RST);
    chk8(psw, PSW_RST);
    chk16(sixteen_bit_data_pointer, DATA_POINTER_RST);
    chk8({6'h00, busy, done}, 8'h00);
    e_acc = ACC_RST;
    e_psw = PSW_RST;
  endtask : s_reset

  // immediate comes from operand1; other sources from mem_data
  task automatic s_group(input logic [3:0] hi);
    logic [7:0] a;
    logic [7:0] s;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? vals[i] : 8'h30 + 8'(i);
      do_op({hi, forms[i]}, a, 8'h00, (i == 0) ? 8'hEE : vals[i], CYC_ONE);
      case (hi)
        HI_LOGICAL_AND_OP: set_acc(e_acc & vals[i]);
        HI_LOGICAL_OR_OP: set_acc(e_acc | vals[i]);
        HI_LOGICAL_XOR_OP: set_acc(e_acc ^ vals[i]);
        default: exp_arith(vals[i], (hi != HI_ADD) & e_psw[PSW_CY],
          hi == HI_SUBTRACT_WITH_BORROW);
      endcase
      chk_state();
      s = (i == 3) ? {3'h0, e_psw[PSW_RS1], e_psw[PSW_RS0], 3'h6} : a;
      if (i > 0) chk8(src_addr, s);
    end
  endtask : s_group

  task automatic s_wback();
    logic [7:0] w;
    logic [2:0] n;
    for (int i = 0; i < 4; i++) begin
      w = wr_count;
      n = (i == 3) ? CYC_ONE : CYC_TWO;
      rd_addr = 8'h50 + 8'(i);
      do_op(wb_ops[i], 8'h50 + 8'(i), 8'h3C, 8'hA6, n);
      chk8(rd_data, (i == 3) ? (8'hA6 ^ e_acc) : wb_exp[i]);
      chk8(wr_count, w + 8'h01);
      chk_state();
    end
  endtask : s_wback

  task automatic s_rot();
    logic c;
    // a nonzero pattern so that both ends of the ring are exercised
    do_op({HI_ADD, FRM_IMM}, 8'hC5, 8'h00, 8'h00, CYC_ONE);
    exp_arith(8'hC5, 1'b0, 1'b0);
    chk_state();
    for (int j = 0; j < 4; j++) begin
      c = e_psw[PSW_CY];
      if (j < 2) do_op(OP_ROTATE_LEFT_VIA_CARRY, 8'h00, 8'h00, 8'h00, CYC_ONE);
      else do_op(OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 8'h00, 8'h00, CYC_ONE);
      if (j < 2) {e_psw[PSW_CY], e_acc} = {e_acc, c};
      else {e_acc, e_psw[PSW_CY]} = {c, e_acc};
      set_acc(e_acc);
      chk_state();
    end
  endtask : s_rot

  // b stays zero: divide hits the zero case, multiply yields zero
  task automatic s_muldiv();
    do_op(OP_DIV, 8'h00, 8'h00, 8'h00, CYC_FOUR);
    chk8(acc, e_acc);
    chk8(breg, 8'h00);
    chk8({7'h00, psw[PSW_OV]}, 8'h01);
    do_op(OP_MUL, 8'h00, 8'h00, 8'h00, CYC_FOUR);
    e_psw[PSW_CY] = 1'b0;
    e_psw[PSW_OV] = 1'b0;
    set_acc(8'h00);
    chk_state();
    do_op(8'h24, 8'h38, 8'h00, 8'h00, CYC_ONE);
    exp_arith(8'h38, 1'b0, 1'b0);
    do_op(8'h24, 8'h45, 8'h00, 8'h00, CYC_ONE);
    exp_arith(8'h45, 1'b0, 1'b0);
    do_op(OP_DA, 8'h00, 8'h00, 8'h00, CYC_ONE);
    set_acc(8'h83);
    chk_state();
  endtask : s_muldiv

  // a complement held valid while busy must not be taken
  task automatic s_refuse();
    int k;
    k = 3;
    req <= '{1'b1, OP_MUL, 8'h00, 8'h00, 8'h00};
    @(negedge clk_sys);
    req.opcode <= OP_CPL;
    repeat (3) @(negedge clk_sys);
    req.valid <= 1'b0;
    wait_done(k);
    chk8(8'(k), 8'(CYC_FOUR));
    set_acc(8'h00);
    chk_state();
    repeat (2) @(negedge clk_sys);
    chk8({7'h00, busy}, 8'h00);
    chk8(acc, 8'h00);
  endtask : s_refuse

  task automatic s_sixteen_bit_data_pointer();
    for (int i = 1; i <= 256; i++) begin
      do_op(OP_INC_DP, 8'h00, 8'h00, 8'h00, CYC_TWO);
      if (i >= 255) chk16(sixteen_bit_data_pointer, 16'(i));
    end
  endtask : s_sixteen_bit_data_pointer

  initial begin
    repeat (3) @(negedge clk_sys);
    s_reset();
    @(negedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    s_group(HI_ADD);
    s_group(HI_ADD_WITH_CARRY);
    s_group(HI_SUBTRACT_WITH_BORROW);
    s_group(HI_LOGICAL_OR_OP);
    s_group(HI_LOGICAL_XOR_OP);
    s_group(HI_LOGICAL_AND_OP);
    s_wback();
    s_rot();
    s_muldiv();
    s_refuse();
    s_sixteen_bit_data_pointer();
    give_verdict();
  end
endmodule : accumulator_arith_logic_unit_test
